/* host_pin_mux.sv */
// Purpose: Four-pin multiplexer, event flags and host clock output
// Assumes: Register accesses arrive already decoded from the serial port
// Notes:   rc_clk_i and pin inputs are asynchronous and synchronised here
//
// Functional notes
// - Four pins, each configured on its own
// - Codes 0-3: irq, reset, wakeup, battery
// - Codes 4-8: transmit clock, state, FIFO, receive data
// - Codes 9-16: receive clock, state, FIFO, detectors
// - Codes 17-21: host clock, trx, high, low, ext reg enable
// - Codes 22-31: controller state conditions
// - Flags show events; host read clears
// - Mask bit zero blocks the interrupt
// - Ready flag on ready with crystal settled
// - Input codes 0-4 functions, rest unused
// - RC source in sleep, else crystal
// - Crystal ratio field selects sixteen divisions
// - Standby tail of 0/64/256/512 cycles
// - Interrupt when the standby tail starts
// - Source switch glitch-free on RC edge
// - Host clock depends on operating state
// - Clock config fields at bits 7..0
// - Pin config select 7:3, mode 1:0
`timescale 1ns/10ps
`default_nettype none
`include "host_pin_cfg.svh"

module host_pin_mux
#(
  parameter int NUM_PINS = 4  // Pin count
)
(
  // Clock, reset, enable
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  // Register access
  input  wire host_pin_pkg::reg_req_type     reg_req_i,
  output logic [7:0]                         rdata_o,
  // Radio core
  input  wire host_pin_pkg::core_status_type core_i,
  input  wire host_pin_pkg::radio_state_type state_i,
  input  wire logic                          crystal_settled_i,
  input  wire logic [`NUM_EVENTS-1:0]        events_i,
  input  wire logic                          rc_clk_i,
  output host_pin_pkg::pin_func_type         func_o,
  output logic                               interrupt_request_n_o,
  // Pins
  input  wire logic [NUM_PINS-1:0]           pin_in_i,
  output logic [NUM_PINS-1:0]                pin_out_o,
  output logic [NUM_PINS-1:0]                pin_oe_n_o,
  output logic [NUM_PINS-1:0]                pin_high_drive_o
);
  import host_pin_pkg::*;

  // True when addr falls in the four-byte group at base
  function automatic logic in_group(input logic [7:0] addr, input logic [7:0] base);
    return addr[7:2] == base[7:2];
  endfunction

  // Reset release synchroniser
  logic rst_meta_q;
  logic rst_sync_q;
  wire  rstn = rst_sync_q;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // RC clock comes from another oscillator: two flops before use
  logic rc_meta_q;
  logic rc_sync_q;

  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      rc_meta_q <= 1'b0;
      rc_sync_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rc_meta_q <= rc_clk_i;
      rc_sync_q <= rc_meta_q;
    end
  end

  // Configuration and flag storage
  logic [7:0]             pin_cfg_q [NUM_PINS];  // Per-pin select and mode
  logic [7:0]             hclk_cfg_q;            // Host clock configuration
  logic [`NUM_EVENTS-1:0] mask_q;                // Event masks
  logic [`NUM_EVENTS-1:0] status_q;              // Sticky event flags
  logic [`NUM_EVENTS-1:0] status_d;
  logic [7:0]             rdata_q;               // Read data
  logic                   ready_prev_q;          // Ready condition last cycle
  logic                   irq_n_q;               // Registered request

  // Access decode
  wire       wr_hclk  = reg_req_i.wr & (reg_req_i.addr == `HCLK_CFG_ADDR);
  wire       mask_hit = in_group(reg_req_i.addr, `IRQ_MASK_ADDR);
  wire       stat_hit = in_group(reg_req_i.addr, `IRQ_STAT_ADDR);
  // Byte at the group base holds the top eight flags
  wire [1:0] byte_sel = 2'h3 - reg_req_i.addr[1:0];
  wire       pin_hit  = reg_req_i.addr >= `PIN3_CFG_ADDR && reg_req_i.addr <= `PIN0_CFG_ADDR;
  // Lowest offset holds the highest-numbered pin
  wire [7:0] pin_off  = 8'(`PIN0_CFG_ADDR - reg_req_i.addr);

  // Host clock generator
  logic host_clk;
  logic tail_start;

  host_clock_gen u_clock_gen (
    .clock_i      (clock_i),
    .rstn_i       (rstn),
    .ce_i         (ce_i),
    .rc_level_i   (rc_sync_q),
    .state_i      (state_i),
    .cfg_i        (hclk_cfg_q),
    .host_clk_o   (host_clk),
    .tail_start_o (tail_start)
  );

  // Ready event on each entry into ready with crystal settled
  wire ready_cond = (state_i == ST_READY) & crystal_settled_i;
  wire ready_ev   = ready_cond & ~ready_prev_q;

  // Controller events merged with the two raised here
  wire [`NUM_EVENTS-1:0] ev_set = {events_i[`NUM_EVENTS-1:`EV_TAIL+1], tail_start,
                                   ready_ev, events_i[`EV_READY-1:0]};

  // Bytes cleared by a host read of the flag group
  wire [`NUM_EVENTS-1:0] ev_clr = (reg_req_i.rd && stat_hit) ?
                                  (`NUM_EVENTS'(8'hff) << {byte_sel, 3'h0}) : '0;

  // Set beats clear so no event is lost in the read cycle
  always_comb
  begin
    status_d = (status_q & ~ev_clr) | ev_set;
  end

  // Masked flags drive the active-low request
  wire irq_n_d = ~|(status_q & mask_q);

  // Clock configuration, masks and flags
  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      hclk_cfg_q   <= `HCLK_RST;
      mask_q       <= '0;
      status_q     <= '0;
      ready_prev_q <= 1'b0;
      irq_n_q      <= 1'b1;
    end
    else if (ce_i)
    begin
      ready_prev_q <= ready_cond;
      status_q     <= status_d;
      irq_n_q      <= irq_n_d;
      if (wr_hclk)
        hclk_cfg_q <= reg_req_i.wdata;
      if (reg_req_i.wr && mask_hit)
        mask_q[{byte_sel, 3'h0} +: 8] <= reg_req_i.wdata;
    end
  end

  // Read mux; unmapped offsets read as zero
  logic [7:0] rd_val;

  always_comb
  begin
    rd_val = 8'h00;
    if (pin_hit)
      rd_val = pin_cfg_q[pin_off[1:0]];
    else if (reg_req_i.addr == `HCLK_CFG_ADDR)
      rd_val = hclk_cfg_q;
    else if (mask_hit)
      rd_val = mask_q[{byte_sel, 3'h0} +: 8];
    else if (stat_hit)
      rd_val = status_q[{byte_sel, 3'h0} +: 8];
  end

  // Read data held until the next read
  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else if (ce_i && reg_req_i.rd)
      rdata_q <= rd_val;
  end

  // Signals offered to output selectors, code n at bit n
  wire [31:0] out_vec = {
    core_i.sm_cond,
    core_i.ext_reg_en,
    1'b0,
    1'b1,
    core_i.trx_indicator,
    host_clk,
    core_i.carrier_sense,
    core_i.sync_found,
    core_i.preamble_valid,
    core_i.ant_switch,
    core_i.rxf_almost_empty,
    core_i.rxf_almost_full,
    core_i.rx_state,
    core_i.rx_clk,
    core_i.rx_data,
    core_i.txf_almost_full,
    core_i.txf_almost_empty,
    core_i.tx_state,
    core_i.tx_data_clk,
    core_i.low_batt,
    core_i.wut_expired,
    ~core_i.por,
    irq_n_q
  };

  // Per-pin synchronised input, gated by input mode
  logic [NUM_PINS-1:0] in_act;
  // Per-function, per-pin selection hits
  logic [NUM_PINS-1:0] func_hit [`NUM_IN_FUNCS];

  // Reset values: pin0 has its own, pins 1 to 3 share one
  localparam logic [7:0] PIN_RST [4] = '{`PIN0_RST, `PIN1_RST, `PIN2_RST, `PIN3_RST};

  // One slice per pin, each with its own configuration
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pin
    logic       meta_q;   // First synchroniser stage
    logic       sync_q;   // Second synchroniser stage
    logic       out_q;    // Registered pin level
    wire  [4:0] sel  = pin_cfg_q[p][`PIN_SEL_MSB:`PIN_SEL_LSB];
    wire  [1:0] mode = pin_cfg_q[p][`PIN_MODE_MSB:`PIN_MODE_LSB];
    wire        wr   = reg_req_i.wr & pin_hit & (pin_off == 8'(p));

    // Configuration register; reserved bit 2 stays zero
    always_ff @(posedge clock_i or negedge rstn)
    begin
      if (!rstn)
        pin_cfg_q[p] <= PIN_RST[p];
      else if (ce_i && wr)
        pin_cfg_q[p] <= reg_req_i.wdata & `PIN_CFG_WMASK;
    end

    // Pin level crosses in through two flops
    always_ff @(posedge clock_i or negedge rstn)
    begin
      if (!rstn)
      begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        out_q  <= 1'b0;
      end
      else if (ce_i)
      begin
        meta_q <= pin_in_i[p];
        sync_q <= meta_q;
        out_q  <= out_vec[sel];
      end
    end

    // Input only counts when the pin is in input mode
    assign in_act[p]           = (mode == `MODE_INPUT) & sync_q;
    // Output modes 10 and 11 drive; analog and input float
    assign pin_oe_n_o[p]       = ~mode[1];
    assign pin_high_drive_o[p] = mode == `MODE_OUT_HP;
    assign pin_out_o[p]        = out_q;

    // Codes 5..31 match no function and are ignored
    for (genvar f = 0; f < `NUM_IN_FUNCS; f++)
    begin : g_func
      assign func_hit[f][p] = in_act[p] & (sel == 5'(f));
    end
  end

  // Function levels: any pin selecting the function
  logic [`NUM_IN_FUNCS-1:0] func_lvl;
  for (genvar f = 0; f < `NUM_IN_FUNCS; f++)
  begin : g_lvl
    assign func_lvl[f] = |func_hit[f];
  end

  // Commands act on their rising edge
  logic         cmd_prev_q;   // Previous tx/rx command levels
  logic         rx_prev_q;
  pin_func_type func_q;       // Registered function outputs

  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_prev_q <= 1'b0;
      rx_prev_q  <= 1'b0;
      func_q     <= '0;
    end
    else if (ce_i)
    begin
      cmd_prev_q           <= func_lvl[`IN_TX_CMD];
      rx_prev_q            <= func_lvl[`IN_RX_CMD];
      func_q.tx_cmd        <= func_lvl[`IN_TX_CMD] & ~cmd_prev_q;
      func_q.rx_cmd        <= func_lvl[`IN_RX_CMD] & ~rx_prev_q;
      func_q.tx_data       <= func_lvl[`IN_TX_DATA];
      func_q.ext_wakeup    <= func_lvl[`IN_WAKEUP];
      func_q.dc_timing_clk <= func_lvl[`IN_DC_CLK];
    end
  end

  // Outputs
  assign func_o                = func_q;
  assign rdata_o               = rdata_q;
  assign interrupt_request_n_o = irq_n_q;

endmodule // host_pin_mux
`default_nettype wire

/* host_pin_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts for the pin mux
// Assumes: Included by bare name from every design file that needs it
// Notes:   Register bytes are 8 bits wide
`ifndef HOST_PIN_CFG_SVH
`define HOST_PIN_CFG_SVH

// Register offsets
`define PIN3_CFG_ADDR  8'h02
`define PIN0_CFG_ADDR  8'h05
`define HCLK_CFG_ADDR  8'h06
`define IRQ_MASK_ADDR  8'h90
`define IRQ_STAT_ADDR  8'hf8

// Pin configuration fields
`define PIN_SEL_MSB    7
`define PIN_SEL_LSB    3
`define PIN_MODE_MSB   1
`define PIN_MODE_LSB   0
`define MODE_INPUT     2'h1
`define MODE_OUT_HP    2'h3
`define PIN_CFG_WMASK  8'hfb
`define PIN3_RST       8'ha2
`define PIN2_RST       8'ha2
`define PIN1_RST       8'ha2
`define PIN0_RST       8'h0a

// Host clock configuration fields
`define HCLK_EN_BIT    7
`define TAIL_MSB       6
`define TAIL_LSB       5
`define XDIV_MSB       4
`define XDIV_LSB       1
`define RDIV_BIT       0
`define HCLK_RST       8'h00

// Tail lengths in host clock cycles
`define TAIL_LEN0      10'h000
`define TAIL_LEN1      10'h040
`define TAIL_LEN2      10'h100
`define TAIL_LEN3      10'h200

// RC divide-by-128: toggle every 64 RC edges
`define RC_TOGGLE_LAST 6'h3f

// Event positions
`define EV_READY       16
`define EV_TAIL        17
`define NUM_EVENTS     32

// Input function codes
`define NUM_IN_FUNCS   5
`define IN_TX_CMD      0
`define IN_RX_CMD      1
`define IN_TX_DATA     2
`define IN_WAKEUP      3
`define IN_DC_CLK      4

`endif

/* host_pin_pkg.sv */
// Purpose: Types shared by the pin mux and the host clock generator
// Assumes: Nothing beyond plain SystemVerilog
// Notes:   Numbers live in host_pin_cfg.svh
package host_pin_pkg;

  // Operating state reported by the radio controller
  typedef enum logic [2:0] {
    ST_SHUTDOWN,
    ST_STANDBY,
    ST_SLEEP,
    ST_READY,
    ST_TUNING,
    ST_RX,
    ST_TX
  } radio_state_type;

  // Internal signals offered to the output selectors
  typedef struct packed {
    logic       por;
    logic       wut_expired;
    logic       low_batt;
    logic       tx_data_clk;
    logic       tx_state;
    logic       txf_almost_empty;
    logic       txf_almost_full;
    logic       rx_data;
    logic       rx_clk;
    logic       rx_state;
    logic       rxf_almost_full;
    logic       rxf_almost_empty;
    logic       ant_switch;
    logic       preamble_valid;
    logic       sync_found;
    logic       carrier_sense;
    logic       trx_indicator;
    logic       ext_reg_en;
    logic [9:0] sm_cond;
  } core_status_type;

  // Input functions fed from the pins
  typedef struct packed {
    logic tx_cmd;
    logic rx_cmd;
    logic tx_data;
    logic ext_wakeup;
    logic dc_timing_clk;
  } pin_func_type;

  // One register access from the serial port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage

/* host_clock_gen.sv */
// Purpose: Divided host clock from crystal or RC, with standby tail
// Assumes: rc_level_i is already synchronised to clock_i
// Notes:   Edges of host_clk_o fall on clock_i edges only
`timescale 1ns/10ps
`default_nettype none
`include "host_pin_cfg.svh"

module host_clock_gen
(
  // Clock, reset, enable
  input  wire logic                   clock_i,
  input  wire logic                   rstn_i,
  input  wire logic                   ce_i,
  // Sources and control
  input  wire logic                   rc_level_i,
  input  wire host_pin_pkg::radio_state_type state_i,
  input  wire logic [7:0]             cfg_i,
  // Outputs
  output logic                        host_clk_o,
  output logic                        tail_start_o
);
  import host_pin_pkg::*;

  // Crystal period in clock_i cycles; 1 and 2/3 limited to fastest (2)
  localparam logic [7:0] XO_PER [16] = '{8'h02, 8'h02, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0c,
                                         8'h10, 8'h18, 8'h24, 8'h30, 8'h40, 8'h60, 8'h80, 8'hc0};
  // Tail lengths by field code
  localparam logic [9:0] TAIL_TAB [4] = '{`TAIL_LEN0, `TAIL_LEN1, `TAIL_LEN2, `TAIL_LEN3};

  logic [7:0] xcnt_q;      // Crystal divider phase
  logic [5:0] rcnt_q;      // RC edge count
  logic       rdiv_q;      // RC divided by 128
  logic       rc_prev_q;   // Last RC level, for edge find
  logic       src_rc_q;    // Current source is RC
  logic [9:0] tail_q;      // Tail cycles still owed
  logic       stby_q;      // Was in standby last cycle
  logic       clk_q;       // Host clock flop
  logic       start_q;     // Tail start pulse

  wire        en       = cfg_i[`HCLK_EN_BIT];
  wire [7:0]  period   = XO_PER[cfg_i[`XDIV_MSB:`XDIV_LSB]];
  wire [7:0]  high_len = 8'((period + 8'h01) >> 1);
  wire        xo_out   = xcnt_q < high_len;
  wire        rc_rise  = rc_level_i & ~rc_prev_q;
  wire        rc_out   = cfg_i[`RDIV_BIT] ? rdiv_q : rc_level_i;
  wire        want_rc  = state_i == ST_SLEEP;
  wire        in_stby  = state_i == ST_STANDBY;
  wire        enter_sb = in_stby & ~stby_q;
  wire        active   = state_i inside {ST_READY, ST_TUNING, ST_RX, ST_TX, ST_SLEEP};
  // No clock in shutdown, tail only in standby
  wire        run      = en & (active | (in_stby & (tail_q != 10'h000)));
  wire        clk_d    = run & (src_rc_q ? rc_out : xo_out);
  wire [9:0]  tail_len = TAIL_TAB[cfg_i[`TAIL_MSB:`TAIL_LSB]];

  // Dividers free-run while enabled
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      xcnt_q    <= 8'h00;
      rcnt_q    <= 6'h00;
      rdiv_q    <= 1'b0;
      rc_prev_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rc_prev_q <= rc_level_i;
      xcnt_q    <= (!en || xcnt_q >= period - 8'h01) ? 8'h00 : xcnt_q + 8'h01;
      if (rc_rise)
      begin
        rcnt_q <= rcnt_q + 6'h01;
        if (rcnt_q == `RC_TOGGLE_LAST)
          rdiv_q <= ~rdiv_q;
      end
    end
  end

  // Source swap only on an RC rising edge, while output is low
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      src_rc_q <= 1'b0;
    else if (ce_i && rc_rise && !clk_q && want_rc != src_rc_q)
      src_rc_q <= want_rc;
  end

  // Standby tail: load on entry, count host clock rising edges
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tail_q  <= 10'h000;
      stby_q  <= 1'b0;
      clk_q   <= 1'b0;
      start_q <= 1'b0;
    end
    else if (ce_i)
    begin
      stby_q  <= in_stby;
      clk_q   <= clk_d;
      start_q <= enter_sb;  // Warn the host as the tail begins
      if (enter_sb)
        tail_q <= tail_len;
      else if (in_stby && clk_d && !clk_q && tail_q != 10'h000)
        tail_q <= tail_q - 10'h001;
    end
  end

  assign host_clk_o   = clk_q;
  assign tail_start_o = start_q;

endmodule // host_clock_gen
`default_nettype wire

/* host_pin_mux_sva.sv */
// Purpose: Port checks for host_pin_mux
// Assumes: Shadows follow register writes
// Notes:   Of the pin configs only pin0 is shadowed, to keep helper logic small
`timescale 1ns/10ps
`default_nettype none
`include "host_pin_cfg.svh"
module host_pin_mux_sva
  import host_pin_pkg::*;
#(
  parameter int NUM_PINS = 4  // Pin count
)
(
  // Clock and reset
  input wire logic                          clock_i,
  input wire logic                          rstn_i,
  input wire logic                          ce_i,
  // Register port and core side
  input wire host_pin_pkg::reg_req_type     reg_req_i,
  input wire logic [7:0]                    rdata_o,
  input wire host_pin_pkg::core_status_type core_i,
  input wire host_pin_pkg::radio_state_type state_i,
  input wire host_pin_pkg::pin_func_type    func_o,
  input wire logic                          interrupt_request_n_o,
  // Pins
  input wire logic [NUM_PINS-1:0]           pin_in_i,
  input wire logic [NUM_PINS-1:0]           pin_out_o,
  input wire logic [NUM_PINS-1:0]           pin_oe_n_o
);
  logic [3:0] rs_q;    // Release mirror, later than the design's own
  logic [7:0] pin0_q;  // Pin0 config shadow
  logic [7:0] hclk_q;  // Host clock config shadow
  wire  [4:0] sel0 = pin0_q[7:3];  // Pin0 output select

  // Shadows; the reserved bit never sticks
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
    begin
      rs_q   <= 4'h0;
      pin0_q <= `PIN0_RST;
      hclk_q <= `HCLK_RST;
    end
    else if (ce_i)
    begin
      rs_q   <= {rs_q[2:0], 1'b1};
      if (reg_req_i.wr && reg_req_i.addr == `PIN0_CFG_ADDR)
        pin0_q <= reg_req_i.wdata & `PIN_CFG_WMASK;
      if (reg_req_i.wr && reg_req_i.addr == `HCLK_CFG_ADDR)
        hclk_q <= reg_req_i.wdata;
    end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rs_q[3]);

  // A pin input rose three samples back
  sequence s_pin_rose;
    ($past(pin_in_i, 3) & ~$past(pin_in_i, 4)) != '0;
  endsequence
  // Host clock on pin0 while it has to be stopped
  sequence s_clock_off;
    ($past(sel0) == 5'h11 && (state_i == ST_SHUTDOWN || !hclk_q[`HCLK_EN_BIT])) [*8];
  endsequence

  a_const_high: assert property ($past(sel0) == 5'h13 |-> pin_out_o[0])
    else $error("pin0 not high");
  a_const_low: assert property ($past(sel0) == 5'h14 |-> !pin_out_o[0])
    else $error("pin0 not low");
  a_irq_pin: assert property ($past(sel0) == 5'h00 |-> pin_out_o[0] == $past(interrupt_request_n_o))
    else $error("pin0 not irq");
  a_por_pin: assert property ($past(sel0) == 5'h01 |-> pin_out_o[0] == !$past(core_i.por))
    else $error("pin0 not inverted por");
  a_drive_mode: assert property (pin_oe_n_o[0] == !pin0_q[1])
    else $error("pin0 enable wrong");
  a_clock_stops: assert property (s_clock_off |-> !pin_out_o[0])
    else $error("host clock not stopped");
  a_tx_pulse: assert property (func_o.tx_cmd |=> !func_o.tx_cmd)
    else $error("tx command too long");
  a_cmd_cause: assert property ($rose(func_o.tx_cmd) |-> s_pin_rose)
    else $error("tx command without pin rise");
  a_cfg_read: assert property (reg_req_i.rd && reg_req_i.addr == `HCLK_CFG_ADDR |=> rdata_o == $past(hclk_q))
    else $error("clock config readback");
endmodule // host_pin_mux_sva
bind host_pin_mux host_pin_mux_sva #(.NUM_PINS(NUM_PINS)) u_host_pin_mux_sva (.clock_i(clock_i),
  .rstn_i(rstn_i), .ce_i(ce_i), .reg_req_i(reg_req_i), .rdata_o(rdata_o), .core_i(core_i),
  .state_i(state_i), .func_o(func_o), .interrupt_request_n_o(interrupt_request_n_o),
  .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));
`default_nettype wire

/* host_mcu_model.sv */
// Purpose: Host controller on the far side of the pins
// Assumes: An undriven pin floats; shown as a flipping level
// Notes:   Measures the host clock on pin0 in clock_i cycles
`timescale 1ns/10ps
`default_nettype none
module host_mcu_model
(
  // Clock
  input  wire logic        clock_i,
  // Pin side
  input  wire logic [3:0]  pin_out_i,
  input  wire logic [3:0]  pin_oe_n_i,
  output logic      [3:0]  pin_in_o,
  // Bench control
  input  wire logic [3:0]  drv_lvl_i,
  input  wire logic [3:0]  drv_en_i,
  input  wire logic        clr_i,
  output logic      [15:0] edges_o,
  output logic      [15:0] period_o
);
  logic        alt_q   = 1'b0;      // Floating level
  logic        last_q  = 1'b0;      // Pin0 one cycle back
  logic [15:0] cyc_q   = 16'h0000;  // Cycle count
  logic [15:0] stamp_q = 16'h0000;  // Cycle of last rise
  logic        rise;                // Pin0 rose

  // Device drive wins, then host, else float
  assign pin_in_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & (drv_en_i & drv_lvl_i | ~drv_en_i & {4{alt_q}}));
  assign rise = pin_in_o[0] & ~last_q;

  // Tail edges counted so the host can wind down before its clock stops
  always_ff @(posedge clock_i)
  begin
    alt_q   <= ~alt_q;
    last_q  <= pin_in_o[0];
    cyc_q   <= cyc_q + 16'h0001;
    edges_o <= clr_i ? 16'h0000 : edges_o + {15'h0000, rise};
    if (rise)
    begin
      period_o <= cyc_q - stamp_q;
      stamp_q  <= cyc_q;
    end
  end
endmodule // host_mcu_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for host_pin_mux
// Assumes: ce_i held high; the model plays the host
// Notes:   Expectations come from the tables below
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import host_pin_pkg::*;
  logic            clock_i = 1'b0;       // System clock
  logic            rstn_i  = 1'b0;       // Reset, active low
  logic            rc_clk  = 1'b0;       // RC oscillator
  logic            clr     = 1'b1;       // Model count clear
  reg_req_type     req     = '0;         // Register request
  core_status_type core    = '0;         // Core levels
  radio_state_type state   = ST_SHUTDOWN; // Operating state
  logic            xset    = 1'b0;       // Crystal settled
  logic [31:0]     events  = '0;         // Event pulses
  logic [3:0]      drv_lvl = '0, drv_en = '0; // Host pin levels and drive
  logic [7:0]      rdata;                // Read data
  pin_func_type    func;                 // Input functions
  logic            irq_n;                // Interrupt request
  logic [3:0]      pin_in, pin_out, pin_oe_n, pin_hd;
  logic [15:0]     edges, period;        // Model measurements
  int              n_fail = 0;           // Mismatches
  int              total_checks = 0;     // Comparisons
  // Output rows: core bit raised per code, -1 for fixed outputs
  localparam int bit_of [32] = '{-1, 27, 26, 25, 24, 23, 22, 21, 20, 19, 18, 17, 16, 15, 14, 13,
                                 12, -1, 11, -1, -1, 10, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9};
  // Crystal rows: ratio code beside its period
  localparam int xcode [4] = '{2, 3, 4, 15};
  localparam int xper [4]  = '{2, 3, 4, 192};

  host_pin_mux u_host_pin_mux (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1), .reg_req_i(req),
    .rdata_o(rdata), .core_i(core), .state_i(state), .crystal_settled_i(xset), .events_i(events),
    .rc_clk_i(rc_clk), .func_o(func), .interrupt_request_n_o(irq_n), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .pin_high_drive_o(pin_hd));
  host_mcu_model u_host_mcu_model (.clock_i(clock_i), .pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n),
    .pin_in_o(pin_in), .drv_lvl_i(drv_lvl), .drv_en_i(drv_en), .clr_i(clr), .edges_o(edges),
    .period_o(period));

  initial forever #5 clock_i = ~clock_i;
  // RC period unrelated to the system clock
  initial forever #37 rc_clk = ~rc_clk;

  function automatic logic exp_of(input int c, input logic on);
    if (c == 0 || c == 19) return 1'b1;
    if (c == 17 || c == 20) return 1'b0;
    return on ^ (c == 1);
  endfunction
  function automatic logic [4:0] exp_func(input int c, input logic fresh);
    return (c < 5 && (fresh || c > 1)) ? 5'h10 >> c : 5'h00;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) req <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i) req <= '0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i) req <= '0;
    #1 chk("rdata", rdata, exp);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, well past the expected run length
  initial
  begin
    repeat (40000) @(posedge clock_i);
    n_fail++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    tick(20);
    @(posedge clock_i) rstn_i <= 1'b1;
    tick(4);
    for (int c = 0; c < 32; c++)
    begin
      wr(8'h05, {c[4:0], 3'b011});
      for (int v = 0; v < 2; v++)
      begin
        @(posedge clock_i) core <= (bit_of[c] >= 0 && v == 0) ? core_status_type'(28'h1 << bit_of[c]) : '0;
        tick(3);
        chk("pin0", pin_out[0], exp_of(c, v == 0));
      end
      chk("drive", pin_hd[0], 1'b1);
    end
    wr(8'h02, {5'd19, 3'b010});
    tick(3);
    chk("pins", pin_out[3:1], 3'b100);
    $display("output selection done");
    for (int c = 0; c < 6; c++)
    begin
      @(posedge clock_i) drv_en <= 4'b0100;
      drv_lvl <= 4'b0000;
      wr(8'h03, {c[4:0], 3'b001});
      tick(4);
      @(posedge clock_i) drv_lvl <= 4'b0100;
      tick(3);
      chk("func", func, exp_func(c, 1'b1));
      tick(1);
      chk("func", func, exp_func(c, 1'b0));
    end
    wr(8'h03, 8'ha2);
    $display("input selection done");
    wr(8'h93, 8'h08);
    wr(8'h04, 8'h02);
    @(posedge clock_i) events[3] <= 1'b1;
    @(posedge clock_i) events[3] <= 1'b0;
    tick(4);
    chk("irq", {irq_n, pin_out[1]}, 2'b00);
    rdc(8'hfb, 8'h08);
    tick(3);
    chk("irq", irq_n, 1'b1);
    rdc(8'hfb, 8'h00);
    @(posedge clock_i) events[4] <= 1'b1;
    @(posedge clock_i) events[4] <= 1'b0;
    tick(4);
    chk("irq", irq_n, 1'b1);
    rdc(8'hfb, 8'h10);
    $display("interrupt done");
    @(posedge clock_i) state <= ST_READY;
    xset <= 1'b1;
    clr <= 1'b0;
    wr(8'h05, {5'd17, 3'b010});
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h06, 8'h80 | 8'(xcode[i] << 1));
      tick(600);
      chk("xo_period", period, xper[i]);
    end
    rdc(8'h06, 8'h9e);
    rdc(8'hf9, 8'h01);
    wr(8'h91, 8'h02);
    wr(8'h06, 8'ha8);
    tick(50);
    @(posedge clock_i) state <= ST_STANDBY;
    clr <= 1'b1;
    @(posedge clock_i) clr <= 1'b0;
    tick(400);
    chk("tail", edges inside {16'd64, 16'd65}, 1'b1);
    chk("tail_irq", {irq_n, pin_out[0]}, 2'b00);
    rdc(8'hf9, 8'h02);
    @(posedge clock_i) state <= ST_SLEEP;
    wr(8'h06, 8'h80);
    tick(200);
    chk("rc1", period inside {16'd7, 16'd8}, 1'b1);
    wr(8'h06, 8'h81);
    tick(3000);
    chk("rc128", period inside {16'd947, 16'd948}, 1'b1);
    @(posedge clock_i) state <= ST_SHUTDOWN;
    tick(10);
    chk("off", pin_out[0], 1'b0);
    rdc(8'h10, 8'h00);
    wr(8'h05, 8'hff);
    rdc(8'h05, 8'hfb);
    $display("host clock done");
    @(posedge clock_i) rstn_i <= 1'b0;
    tick(3);
    @(posedge clock_i) rstn_i <= 1'b1;
    tick(4);
    rdc(8'h02, 8'ha2);
    rdc(8'h05, 8'h0a);
    rdc(8'h06, 8'h00);
    chk("oe", pin_oe_n, 4'h0);
    $display("reset done");
    results();
  end
endmodule // tb_top
`default_nettype wire
